// ---- rpb_pkg.sv ----
// package: register map, field positions, reset values for the bridge config header
package rpb_pkg;
  // byte offsets within configuration space
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STS = 8'h06;
  localparam logic [7:0] OFS_REV = 8'h08;
  localparam logic [7:0] OFS_CLS = 8'h09;
  localparam logic [7:0] OFS_CLSZ = 8'h0c;
  localparam logic [7:0] OFS_HDR = 8'h0e;
  localparam logic [7:0] OFS_PBUS = 8'h18;
  localparam logic [7:0] OFS_SBUS = 8'h19;
  localparam logic [7:0] OFS_SUBUS = 8'h1a;
  localparam logic [7:0] OFS_IOB = 8'h1c;
  localparam logic [7:0] OFS_IOL = 8'h1d;
  localparam logic [7:0] OFS_SSTS = 8'h1e;
  // command field positions
  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_REQ_EN = 2;
  localparam int CMD_PAR_EN = 6;
  localparam int CMD_SERR_EN = 8;
  localparam int CMD_INTX_DIS = 10;
  // status field positions
  localparam int STS_INT = 3;
  localparam int STS_CAP = 4;
  localparam int STS_MPAR = 8;
  localparam int STS_SSE = 14;
  // writable masks of command byte 0 and byte 1
  localparam logic [7:0] CMD_LO_WMASK = 8'h47;
  localparam logic [7:0] CMD_HI_WMASK = 8'h05;
  // reset and constant values
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [23:0] CLASS_VAL = 24'h0604_00;
  localparam logic [7:0] HDR_VAL = 8'h01;
  localparam logic [7:0] PBUS_VAL = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] IOB_RST = 4'hf;
  localparam logic [3:0] IOL_RST = 4'h0;
  localparam logic [11:0] IO_LOW_BOT = 12'h000;
  localparam logic [11:0] IO_LOW_TOP = 12'hfff;
  // upstream request classes
  typedef enum logic [1:0] {
    RPB_UP_MEM_RD = 2'b00,
    RPB_UP_MEM_WR = 2'b01,
    RPB_UP_IO_RD = 2'b10,
    RPB_UP_IO_WR = 2'b11
  } rpb_up_kind_t;
endpackage

// ---- rpb_win_match.sv ----
// window comparator: inclusive base..limit match on one address nibble range
module rpb_win_match #(
  parameter int W = 4
) (
  // window bounds and address
  input wire logic i_en,
  input wire logic [W-1:0] i_base,
  input wire logic [W-1:0] i_limit,
  input wire logic [W-1:0] i_addr,
  // result
  output logic o_hit
);
  initial begin
    if (W < 1) $error("window width must be positive");
  end
  // both ends inclusive; an inverted window matches nothing
  assign o_hit = i_en && (i_addr >= i_base) && (i_addr <= i_limit);
endmodule

// ---- rpb_cfg_header.sv ----
// bridge type-1 configuration header: registers, io decode and upstream gating
module rpb_cfg_header #(
  parameter logic [7:0] REV_ID = 8'h5a  // arbitrary value, tie to the component revision
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // configuration access, byte lane writes, up to four lanes in one cycle
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // error and interrupt events
  input wire logic i_err_detect,
  input wire logic i_mpar_event,
  input wire logic i_pm_int,
  input wire logic i_hp_int,
  input wire logic [15:0] i_sec_status,
  output logic o_serr_msg,
  output logic o_intx_assert,
  // downstream io and memory decode
  input wire logic i_io_valid,
  input wire logic [15:0] i_io_addr,
  output logic o_io_fwd,
  input wire logic [31:0] i_mem_addr,
  input wire logic i_mem_hit_np,
  input wire logic i_mem_hit_pf,
  output logic o_mem_fwd,
  // upstream requests from the link
  input wire logic i_up_valid,
  input wire logic [1:0] i_up_kind,
  input wire logic [31:0] i_up_addr,
  input wire logic [3:0] i_up_be,
  output logic o_up_valid,
  output logic [31:0] o_up_addr,
  output logic [3:0] o_up_be,
  output logic o_up_unsupported,
  // completions toward secondary side
  input wire logic i_cpl_valid,
  output logic o_cpl_fwd
);

  typedef struct packed {
    logic [15:0] cmd;
    logic system_error_signaled;
    logic mpar;
    logic [7:0] clsz;
    logic [7:0] sbus;
    logic [7:0] subus;
    logic [3:0] iob;
    logic [3:0] iol;
    logic [31:0] rdata;
    logic rvalid;
    logic serr;
    logic io_fwd;
    logic mem_fwd;
    logic up_valid;
    logic [31:0] up_addr;
    logic [3:0] up_be;
    logic up_ur;
    logic cpl_fwd;
  } rpb_state_t;

  rpb_state_t st_r;
  rpb_state_t st_nxt;
  logic io_hit;
  logic [15:0] sts_view;
  logic [31:0] rd_word;
  logic [7:0] dw_addr;

  // io window compare on address bits 15:12
  rpb_win_match #(
    .W(4)
  ) u_io_win (
    .i_en(st_r.cmd[rpb_pkg::CMD_IO_EN]),
    .i_base(st_r.iob),
    .i_limit(st_r.iol),
    .i_addr(i_io_addr[15:12]),
    .o_hit(io_hit)
  );

  // primary status as read; hardwired bits fixed here
  always_comb begin
    sts_view = 16'h0000;
    sts_view[rpb_pkg::STS_SSE] = st_r.system_error_signaled;
    sts_view[rpb_pkg::STS_CAP] = 1'b1;
    sts_view[rpb_pkg::STS_INT] = i_pm_int | i_hp_int;
  end

  // read mux per dword, narrow registers packed in their lanes
  assign dw_addr = {i_cfg_addr[7:2], 2'b00};
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (dw_addr)
      rpb_pkg::OFS_CMD: rd_word = {sts_view, st_r.cmd};
      rpb_pkg::OFS_REV: rd_word = {rpb_pkg::CLASS_VAL, REV_ID};
      rpb_pkg::OFS_CLSZ: rd_word = {8'h00, rpb_pkg::HDR_VAL, 8'h00, st_r.clsz};
      rpb_pkg::OFS_PBUS: rd_word = {8'h00, st_r.subus, st_r.sbus, rpb_pkg::PBUS_VAL};
      rpb_pkg::OFS_IOB: rd_word = {i_sec_status, st_r.iol, 4'h0, st_r.iob, 4'h0};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next-state: register writes, flags, decode and upstream gating
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = i_cfg_rd;
    st_nxt.rdata = i_cfg_rd ? rd_word : st_r.rdata;
    if (i_cfg_wr) begin
      unique case (dw_addr)
        rpb_pkg::OFS_CMD: begin
          // only implemented command bits take writes
          if (i_cfg_be[0]) begin
            st_nxt.cmd[7:0] = i_cfg_wdata[7:0] & rpb_pkg::CMD_LO_WMASK;
          end
          if (i_cfg_be[1]) begin
            st_nxt.cmd[15:8] = i_cfg_wdata[15:8] & rpb_pkg::CMD_HI_WMASK;
          end
          // write one clears the signaled flag
          // status sits in the upper half, so bit 14 rides on word bit 30
          if (i_cfg_be[3] && i_cfg_wdata[16 + rpb_pkg::STS_SSE]) begin
            st_nxt.system_error_signaled = 1'b0;
          end
        end
        rpb_pkg::OFS_CLSZ: begin
          if (i_cfg_be[0]) st_nxt.clsz = i_cfg_wdata[7:0];
        end
        rpb_pkg::OFS_PBUS: begin
          if (i_cfg_be[1]) st_nxt.sbus = i_cfg_wdata[15:8];
          if (i_cfg_be[2]) st_nxt.subus = i_cfg_wdata[23:16];
        end
        rpb_pkg::OFS_IOB: begin
          if (i_cfg_be[0]) st_nxt.iob = i_cfg_wdata[7:4];
          if (i_cfg_be[1]) st_nxt.iol = i_cfg_wdata[15:12];
        end
        default: st_nxt.cmd = st_r.cmd; // revision, class and unmapped dwords: writes dropped
      endcase
    end
    // an error message goes out only when enabled; set beats clear
    st_nxt.serr = i_err_detect && st_r.cmd[rpb_pkg::CMD_SERR_EN];
    if (st_nxt.serr) st_nxt.system_error_signaled = 1'b1;
    // master parity never settable with reporting disabled
    if (i_mpar_event && st_r.cmd[rpb_pkg::CMD_PAR_EN]) st_nxt.mpar = 1'b1;
    // downstream decodes
    st_nxt.io_fwd = i_io_valid && io_hit;
    st_nxt.mem_fwd = st_r.cmd[rpb_pkg::CMD_MEM_EN] && (i_mem_hit_np || i_mem_hit_pf);
    // completions ignore every enable
    st_nxt.cpl_fwd = i_cpl_valid;
    // upstream: disabled requests become harmless illegal cycles
    st_nxt.up_valid = i_up_valid;
    if (st_r.cmd[rpb_pkg::CMD_REQ_EN]) begin
      st_nxt.up_addr = i_up_addr;
      st_nxt.up_be = i_up_be;
      st_nxt.up_ur = 1'b0;
    end else begin
      st_nxt.up_addr = 32'h0000_0000;
      st_nxt.up_be = 4'h0;
      st_nxt.up_ur = i_up_valid && !i_up_kind[0];
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.cmd <= rpb_pkg::CMD_RST;
      st_r.clsz <= rpb_pkg::BYTE_RST;
      st_r.sbus <= rpb_pkg::BYTE_RST;
      st_r.subus <= rpb_pkg::BYTE_RST;
      st_r.iob <= rpb_pkg::IOB_RST;
      st_r.iol <= rpb_pkg::IOL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign o_cfg_rdata = st_r.rdata;
  assign o_cfg_rvalid = st_r.rvalid;
  assign o_serr_msg = st_r.serr;
  // legacy interrupt honours the disable bit, status bit does not
  assign o_intx_assert = (i_pm_int | i_hp_int) & ~st_r.cmd[rpb_pkg::CMD_INTX_DIS];
  assign o_io_fwd = st_r.io_fwd;
  assign o_mem_fwd = st_r.mem_fwd;
  assign o_up_valid = st_r.up_valid;
  assign o_up_addr = st_r.up_addr;
  assign o_up_be = st_r.up_be;
  assign o_up_unsupported = st_r.up_ur;
  assign o_cpl_fwd = st_r.cpl_fwd;

  // checks
  AST_PAR_GATE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !st_r.cmd[rpb_pkg::CMD_PAR_EN] && !st_r.mpar |=> !st_r.mpar)
    else $error("parity flag set while reporting disabled");
  AST_CMD_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_r.cmd[5:3] == 3'b000 && st_r.cmd[15:11] == 5'b00000)
    else $error("hardwired command bits nonzero");
  AST_UP_BLOCK: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_up_valid && !st_r.cmd[rpb_pkg::CMD_REQ_EN] |=> o_up_addr == 32'h0000_0000
    && o_up_be == 4'h0)
    else $error("disabled upstream request leaked address");
  AST_UP_UR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_up_valid && !i_up_kind[0] && !st_r.cmd[rpb_pkg::CMD_REQ_EN]
    |=> o_up_unsupported && o_up_valid)
    else $error("illegal read not unsupported");
  AST_UP_PASS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_up_valid && st_r.cmd[rpb_pkg::CMD_REQ_EN] |=> o_up_addr == $past(i_up_addr)
    && !o_up_unsupported)
    else $error("enabled request altered");
  AST_CPL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cpl_valid |=> o_cpl_fwd)
    else $error("completion dropped");
  AST_MEM_OFF: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !st_r.cmd[rpb_pkg::CMD_MEM_EN] |=> !o_mem_fwd)
    else $error("memory forwarded while disabled");
  AST_IO_WIN: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_io_valid && st_r.cmd[rpb_pkg::CMD_IO_EN] && i_io_addr[15:12] >= st_r.iob
    && i_io_addr[15:12] <= st_r.iol |=> o_io_fwd)
    else $error("io inside window not forwarded");
  AST_IO_OFF: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !st_r.cmd[rpb_pkg::CMD_IO_EN] |=> !o_io_fwd)
    else $error("io forwarded while disabled");
  AST_SSE_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_serr_msg |-> st_r.system_error_signaled ##1 $stable(st_r.system_error_signaled) || $past(i_cfg_wr))
    else $error("signaled error flag not set");
  AST_STS_FIX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sts_view[15] == 1'b0 && sts_view[13:5] == 9'h000 && sts_view[4])
    else $error("status hardwired bits wrong");
  AST_SBUS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_wr && dw_addr == rpb_pkg::OFS_PBUS && i_cfg_be[1]
    |=> st_r.sbus == $past(i_cfg_wdata[15:8]))
    else $error("secondary bus write lost");
  AST_SERR_OFF: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !st_r.cmd[rpb_pkg::CMD_SERR_EN] |=> !o_serr_msg)
    else $error("error message sent while disabled");
  AST_SSE_CLR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_wr && dw_addr == rpb_pkg::OFS_CMD && i_cfg_be[3] && i_cfg_wdata[30]
    && !(i_err_detect && st_r.cmd[rpb_pkg::CMD_SERR_EN]) |=> !st_r.system_error_signaled)
    else $error("signaled error flag not cleared by write one");
  AST_INT_STS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sts_view[rpb_pkg::STS_INT] == (i_pm_int | i_hp_int))
    else $error("internal interrupt status wrong");
  AST_ID_FIX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_rd && dw_addr == rpb_pkg::OFS_REV
    |=> o_cfg_rdata == {rpb_pkg::CLASS_VAL, REV_ID})
    else $error("revision or class code wrong");
  AST_HDR_FIX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_rd && dw_addr == rpb_pkg::OFS_CLSZ
    |=> o_cfg_rdata[23:16] == rpb_pkg::HDR_VAL)
    else $error("header layout wrong");
  AST_PBUS_FIX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cfg_rd && dw_addr == rpb_pkg::OFS_PBUS
    |=> o_cfg_rdata[7:0] == rpb_pkg::PBUS_VAL)
    else $error("primary bus number not zero");
  AST_UP_WR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_up_valid && i_up_kind[0] && !st_r.cmd[rpb_pkg::CMD_REQ_EN]
    |=> o_up_valid && !o_up_unsupported && o_up_be == 4'h0)
    else $error("illegal write not neutralised");
  COV_SERR: cover property (@(posedge i_core_clk) disable iff (i_rst) o_serr_msg);
  COV_MEM: cover property (@(posedge i_core_clk) disable iff (i_rst) o_mem_fwd);
  COV_IOFWD: cover property (@(posedge i_core_clk) disable iff (i_rst) o_io_fwd);
  COV_UR: cover property (@(posedge i_core_clk) disable iff (i_rst) o_up_unsupported);
endmodule

// ---- rpb_link_model.sv ----
// far-side link model: issues upstream requests and completions
module rpb_link_model (
  // clock
  input wire logic i_core_clk,
  // traffic toward the bridge
  output logic o_up_valid,
  output logic [1:0] o_up_kind,
  output logic [31:0] o_up_addr,
  output logic [3:0] o_up_be,
  output logic o_cpl_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_up_valid = 1'b0;
    o_up_kind = 2'b00;
    o_up_addr = 32'h0000_0000;
    o_up_be = 4'h0;
    o_cpl_valid = 1'b0;
  end
  // released address and enable lines show inverted junk; kind keeps the last request
  task automatic up_req(input logic [1:0] k, input logic [31:0] a, input logic [3:0] b);
    @(negedge i_core_clk);
    o_up_valid = 1'b1;
    o_up_kind = k;
    o_up_addr = a;
    o_up_be = b;
    @(negedge i_core_clk);
    o_up_valid = 1'b0;
    o_up_addr = ~a;
    o_up_be = ~b;
  endtask
  task automatic cpl_req();
    @(negedge i_core_clk);
    o_cpl_valid = 1'b1;
    @(negedge i_core_clk);
    o_cpl_valid = 1'b0;
  endtask
endmodule

// ---- root_port_bridge_config_header_tb.sv ----
// self-checking bench for the bridge configuration header
module root_port_bridge_config_header_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [31:0] UPV = 32'h8000_0000;
  localparam logic [31:0] UNS = 32'h4000_0000;
  localparam logic [31:0] IOF = 32'h2000_0000;
  localparam logic [31:0] CPL = 32'h1000_0000;
  localparam logic [31:0] SER = 32'h0800_0000;
  localparam logic [31:0] MEM = 32'h0400_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cwr = 1'b0, crd = 1'b0, err = 1'b0, mpar = 1'b0, pm = 1'b0, hp = 1'b0;
  logic iov = 1'b0, np = 1'b0, pf = 1'b0;
  logic [7:0] ca = 8'h00;
  logic [3:0] cbe = 4'h0;
  logic [31:0] cwd = 32'h0000_0000, seed = 32'd62442, r = 32'h0000_0000;
  logic [15:0] sec = 16'h0000, ioa = 16'h0000;
  logic [31:0] rdat, uaddr, lua, evt;
  logic rv, serr, intx, iofwd, memfwd, uv, uns, cfwd, luv, lcv;
  logic [3:0] ube, lub;
  logic [1:0] luk;
  logic [31:0] q_rd[$], q_ev[$];
  int failures = 0, cmp_count = 0;

  always #12.5 clk = ~clk;

  rpb_cfg_header #(.REV_ID(REV)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_cfg_wr(cwr), .i_cfg_rd(crd), .i_cfg_addr(ca),
    .i_cfg_be(cbe), .i_cfg_wdata(cwd), .o_cfg_rdata(rdat), .o_cfg_rvalid(rv),
    .i_err_detect(err), .i_mpar_event(mpar), .i_pm_int(pm), .i_hp_int(hp),
    .i_sec_status(sec), .o_serr_msg(serr), .o_intx_assert(intx), .i_io_valid(iov),
    .i_io_addr(ioa), .o_io_fwd(iofwd), .i_mem_addr(r), .i_mem_hit_np(np),
    .i_mem_hit_pf(pf), .o_mem_fwd(memfwd), .i_up_valid(luv), .i_up_kind(luk),
    .i_up_addr(lua), .i_up_be(lub), .o_up_valid(uv), .o_up_addr(uaddr), .o_up_be(ube),
    .o_up_unsupported(uns), .i_cpl_valid(lcv), .o_cpl_fwd(cfwd));

  rpb_link_model u_link (.i_core_clk(clk), .o_up_valid(luv), .o_up_kind(luk),
    .o_up_addr(lua), .o_up_be(lub), .o_cpl_valid(lcv));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    failures += q_rd.size() + q_ev.size();
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // watcher: every result retires the oldest note; a result with no note fails
  always @(negedge clk) begin
    evt = {uv, uns, iofwd, cfwd, serr, memfwd, 2'b00, uv ? {ube, uaddr[19:0]} : 24'h00_0000};
    if (!rst && rv) chk(rdat, q_rd.size() ? q_rd.pop_front() : ~rdat);
    if (!rst && evt !== 32'h0000_0000) chk(evt, q_ev.size() ? q_ev.pop_front() : 32'h0000_0000);
  end

  // one config access; strobe is cleared a full cycle before the next one
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    cwr = w;
    crd = !w;
    ca = a;
    cbe = b;
    cwd = d;
    @(negedge clk);
    cwr = 1'b0;
    crd = 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    cfg(1'b0, a, 4'h0, 32'h0000_0000);
  endtask

  // one-cycle event pulse, bits are {io, error, parity, np hit, pf hit}
  task automatic ev(input logic [4:0] s, input logic [15:0] a, input logic [31:0] e);
    if (e !== 32'h0000_0000) q_ev.push_back(e);
    @(negedge clk);
    {iov, err, mpar, np, pf} = s;
    ioa = a;
    @(negedge clk);
    {iov, err, mpar, np, pf} = 5'h00;
  endtask

  task automatic up(input int k, input logic [31:0] a, input logic [31:0] e);
    q_ev.push_back(e);
    u_link.up_req(k[1:0], a, a[27:24]);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    r = xs();
    sec = r[15:0];
    rdx(8'h04, 32'h0010_0000);
    rdx(8'h08, {24'h06_0400, REV});
    rdx(8'h0c, 32'h0001_0000);
    rdx(8'h18, 32'h0000_0000);
    rdx(8'h1c, {sec, 16'h00f0});
    rdx(8'h20, 32'h0000_0000);
    // all ones to every dword but the bus numbers, which take a random word: only writable bits may stick
    cfg(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 8'h1c, 4'hf, 32'hffff_ffff);
    r = xs();
    cfg(1'b1, 8'h18, 4'hf, r);
    rdx(8'h04, 32'h0010_0547);
    rdx(8'h08, {24'h06_0400, REV});
    rdx(8'h0c, 32'h0001_00ff);
    rdx(8'h18, {8'h00, r[23:8], 8'h00});
    rdx(8'h1c, {sec, 16'hf0f0});
    // window 2..5 swept over every top nibble; base stays nonzero
    cfg(1'b1, 8'h1c, 4'h3, 32'h0000_5020);
    for (int n = 0; n < 16; n++) begin
      r = xs();
      ev(5'h10, {n[3:0], r[11:0]}, (n >= 2 && n <= 5) ? IOF : 32'h0000_0000);
    end
    ev(5'h02, 16'h0000, MEM);
    ev(5'h01, 16'h0000, MEM);
    ev(5'h08, 16'h0000, SER);
    ev(5'h04, 16'h0000, 32'h0000_0000);
    rdx(8'h04, 32'h4010_0547);
    cfg(1'b1, 8'h04, 4'h8, 32'h4000_0000);
    pm = 1'b1;
    rdx(8'h04, 32'h0018_0547);
    chk({31'h0000_0000, intx}, 32'h0000_0000);
    q_ev.push_back(CPL);
    u_link.cpl_req();
    for (int k = 0; k < 4; k++) begin
      r = xs();
      up(k, r, UPV | {8'h00, r[27:24], r[19:0]});
    end
    // command cleared: io, memory and error blocked; completions, interrupt and zeroed upstream requests still pass
    cfg(1'b1, 8'h04, 4'h3, 32'h0000_0000);
    pm = 1'b0;
    hp = 1'b1;
    ev(5'h10, 16'h3abc, 32'h0000_0000);
    ev(5'h03, 16'h0000, 32'h0000_0000);
    ev(5'h08, 16'h0000, 32'h0000_0000);
    ev(5'h04, 16'h0000, 32'h0000_0000);
    rdx(8'h04, 32'h0018_0000);
    chk({31'h0000_0000, intx}, 32'h0000_0001);
    q_ev.push_back(CPL);
    u_link.cpl_req();
    for (int k = 0; k < 4; k++) begin
      r = xs();
      up(k, r, k[0] ? UPV : (UPV | UNS));
    end
    repeat (3) @(negedge clk);
    finish_test();
  end

  // watchdog: the sequence needs about 120 cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule
